// >>> common/fptu_pkg.sv
// Shared constants and types of the floating-point trap and register unit.
package fptu_pkg;
	// ****************************************************************
	// Control register numbers and field layout
	// ****************************************************************
	localparam logic [4:0]  CR_IMPREV     = 5'h00;
	localparam logic [4:0]  CR_CSR        = 5'h1F;
	localparam int          CSR_RM_LSB    = 0;
	localparam int          CSR_FLAG_LSB  = 2;
	localparam int          CSR_EN_LSB    = 7;
	localparam int          CSR_CAUSE_LSB = 12;
	localparam int          CSR_UNIMP_BIT = 17;
	localparam int          CSR_COND_BIT  = 23;
	localparam int          IMP_LSB       = 8;
	localparam logic [1:0]  RM_RESET      = 2'h0;
	localparam logic [4:0]  EXC_RESET     = 5'h00;
	// ****************************************************************
	// Exception bit positions inside the cause, enable and flag fields
	// ****************************************************************
	localparam int          EXC_INEXACT   = 0;
	localparam int          EXC_UNDERFLOW = 1;
	localparam int          EXC_OVERFLOW  = 2;
	localparam int          EXC_DIVZERO   = 3;
	localparam int          EXC_INVALID   = 4;
	// ****************************************************************
	// Rounding modes and overflow results
	// ****************************************************************
	localparam logic [1:0]  RM_NEAREST    = 2'h0;
	localparam logic [1:0]  RM_ZERO       = 2'h1;
	localparam logic [1:0]  RM_UP         = 2'h2;
	localparam logic [1:0]  RM_DOWN       = 2'h3;
	localparam logic [62:0] DBL_INF_MAG   = 63'h7FF0000000000000;
	localparam logic [62:0] DBL_MAX_MAG   = 63'h7FEFFFFFFFFFFFFF;
	localparam logic [30:0] SGL_INF_MAG   = 31'h7F800000;
	localparam logic [30:0] SGL_MAX_MAG   = 31'h7F7FFFFF;
	// ****************************************************************
	// Pipeline constants and issue states
	// ****************************************************************
	localparam logic [31:0] INSN_BYTES    = 32'h00000004;
	localparam int          NUM_REGS      = 32;
	typedef enum logic [1:0] {
		FPTU_ISSUE,
		FPTU_SERIAL,
		FPTU_FLUSH
	} fptu_state_t;
endpackage

// >>> common/fptu_rf_if.sv
// Register file access bundle between the trap logic and the register array.
`timescale 1ns/10ps
`default_nettype none
interface fptu_rf_if;
	logic        we;
	logic [4:0]  widx;
	logic        wdbl;
	logic [63:0] wdata;
	logic [4:0]  ridx;
	logic [63:0] rdata;
	logic        mode;
	modport ctl (output we, widx, wdbl, wdata, ridx, mode, input rdata);
	modport rf  (input we, widx, wdbl, wdata, ridx, mode, output rdata);
endinterface
`default_nettype wire

// >>> rtl/fptu_regfile.sv
// Physical floating-point register array with width-mode mapping.
`timescale 1ns/10ps
`default_nettype none
module fptu_regfile #(
	parameter int REG_W = 64
) (
	input  wire logic sys_clk_i,
	fptu_rf_if.rf     bus
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [31:0] lo_q [fptu_pkg::NUM_REGS];
	logic [31:0] hi_q [fptu_pkg::NUM_REGS];
	wire  [4:0]  pair_idx = {bus.ridx[4:1], 1'b1};
	wire  [31:0] hi_rd    = (REG_W == 64) ? hi_q[bus.ridx] : 32'h00000000;

	initial begin
		if (REG_W != 32 && REG_W != 64) begin
			$error("fptu_regfile: REG_W must be 32 or 64");
		end
	end

	// Mode 0 joins an even register with its odd partner; mode 1 uses one wide register.
	// paired lower halves
	assign bus.rdata = bus.mode ? {hi_rd, lo_q[bus.ridx]} : {lo_q[pair_idx], lo_q[bus.ridx]};

	for (genvar i = 0; i < fptu_pkg::NUM_REGS; i++) begin : g_ent
		wire lo_hit = bus.we && bus.widx == 5'(i);
		wire pr_hit = bus.we && !bus.mode && bus.wdbl && {bus.widx[4:1], 1'b1} == 5'(i);
		wire up_hit = bus.we && bus.mode && bus.wdbl && bus.widx == 5'(i);
		always_ff @(posedge sys_clk_i) begin
			if (pr_hit) begin
				lo_q[i] <= bus.wdata[63:32];
			end else if (lo_hit) begin
				lo_q[i] <= bus.wdata[31:0];
			end
		end
		always_ff @(posedge sys_clk_i) begin
			if (up_hit && REG_W == 64) begin
				hi_q[i] <= bus.wdata[63:32];
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/fptu_top.sv
// Floating-point trap decision, control registers and register file front end.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - trapped op leaves registers and successors untouched
// - trap decided in the issue cycle
// - inexact enable serialises operations
// - denormals trap to software
// - older unit traps all but inexact/overflow
// - overflow gives infinity or largest finite
// - sixteen even registers, odd holds high half
// - older unit traps arithmetic on odd registers
// - thirty-two physical registers, 64 or 32 bits
// - width mode 0 pairs registers, even only
// - width mode 1 gives thirty-two full registers
// - narrow unit mode 0 forbids odd, doubles
// - interrupt variant uses one selectable line
// - later unit raises coded exception
// - thirty-two control numbers, two functional
// - control/status holds enables, cause, flags, rounding
// - precise trap, restartable return address, masking
// - delay slot returns to branch, flag set
// - traps continue while interrupt disabled
// - unimplemented condition always traps
module fptu_top #(
	parameter bit         LATER_GEN  = 1'b1,
	parameter int         REG_W      = 64,
	parameter bit         INT_SIGNAL = 1'b0,
	parameter int         INT_LINES  = 6,
	parameter logic [7:0] IMP_CODE   = 8'h5A,
	parameter logic [7:0] REV_CODE   = 8'h11,
	parameter logic [4:0] EXC_CODE   = 5'h10
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 register_width_mode_bit_i,
	input  wire logic                 cpu_int_enable_i,
	input  wire logic [2:0]           int_line_sel_i,
	input  wire logic                 op_valid_i,
	input  wire logic                 op_dbl_i,
	input  wire logic [4:0]           op_fs_i,
	input  wire logic [4:0]           op_ft_i,
	input  wire logic [4:0]           op_fd_i,
	input  wire logic [31:0]          op_pc_i,
	input  wire logic                 op_in_delay_i,
	input  wire logic                 op_no_encoding_i,
	input  wire logic                 op_opnd_denorm_i,
	input  wire logic                 op_opnd_snan_i,
	input  wire logic                 op_res_denorm_i,
	input  wire logic [4:0]           op_exc_i,
	input  wire logic [63:0]          op_result_i,
	input  wire logic                 op_cmp_i,
	input  wire logic                 op_cond_i,
	output logic                      op_ready_o,
	output logic                      op_done_o,
	output logic                      op_trap_o,
	input  wire logic                 mv_we_i,
	input  wire logic                 mv_rd_i,
	input  wire logic [4:0]           mv_idx_i,
	input  wire logic                 mv_dbl_i,
	input  wire logic [63:0]          mv_wdata_i,
	output logic [63:0]               mv_rdata_o,
	input  wire logic [4:0]           reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic [31:0]               reg_rdata_o,
	output logic [1:0]                rounding_mode_o,
	output logic                      fp_exc_o,
	output logic [4:0]                fp_exception_cause_code_o,
	output logic [31:0]               epc_o,
	output logic                      branch_delay_flag_o,
	output logic [INT_LINES-1:0]      cpu_int_o
);
	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	initial begin
		if (REG_W != 32 && REG_W != 64) begin
			$error("fptu_top: REG_W must be 32 or 64");
		end
		if (INT_LINES < 1 || INT_LINES > 8) begin
			$error("fptu_top: INT_LINES must lie between 1 and 8");
		end
	end

	// ****************************************************************
	// Control/status state
	// ****************************************************************
	logic [1:0]            rm;
	logic [4:0]            flags;
	logic [4:0]            enables;
	logic [4:0]            cause;
	logic                  unimp;
	logic                  cond;
	fptu_pkg::fptu_state_t state;
	fptu_pkg::fptu_state_t next_state;

	// ****************************************************************
	// Register file
	// ****************************************************************
	fptu_rf_if rf_bus ();

	fptu_regfile #(
		.REG_W (REG_W)
	) u_regfile (
		.sys_clk_i (sys_clk_i),
		.bus       (rf_bus.rf)
	);

	// The earlier unit behaves as permanently paired registers.
	wire width_mode = LATER_GEN && register_width_mode_bit_i;
	wire narrow     = (REG_W == 32);

	// ****************************************************************
	// Trap decision, resolved combinationally in the issue cycle
	// ****************************************************************
	// decide at issue
	wire take = op_valid_i && op_ready_o;

	wire odd_ref  = !width_mode && (op_fs_i[0] || op_ft_i[0] || op_fd_i[0]);
	wire dbl_bad  = narrow && op_dbl_i;

	// A signalling NaN operand is an invalid operation.
	wire [4:0] ieee_exc = op_exc_i | {op_opnd_snan_i, 4'h0};
	wire [4:0] old_ok   = 5'((1 << fptu_pkg::EXC_INEXACT) | (1 << fptu_pkg::EXC_OVERFLOW));

	// older unit keeps only inexact and overflow
	wire old_unimp = !LATER_GEN && |(ieee_exc & ~old_ok);
	// The later unit emulates invalid results only when that trap is off.
	wire new_unimp = LATER_GEN && ieee_exc[fptu_pkg::EXC_INVALID] && !enables[fptu_pkg::EXC_INVALID];

	wire denorm_unimp = op_opnd_denorm_i || op_res_denorm_i || ieee_exc[fptu_pkg::EXC_UNDERFLOW];

	wire op_unimp = op_no_encoding_i || denorm_unimp || odd_ref || dbl_bad || old_unimp || new_unimp;

	wire op_trap = op_unimp || |(ieee_exc & enables);

	// ****************************************************************
	// Overflow result replacement
	// ****************************************************************
	// rounding picks infinity or maximum
	wire sgn_res = op_dbl_i ? op_result_i[63] : op_result_i[31];
	wire to_inf  = (rm == fptu_pkg::RM_NEAREST) || (rm == fptu_pkg::RM_UP && !sgn_res) ||
		(rm == fptu_pkg::RM_DOWN && sgn_res);
	wire [63:0] ovf_dbl = {sgn_res, to_inf ? fptu_pkg::DBL_INF_MAG : fptu_pkg::DBL_MAX_MAG};
	wire [63:0] ovf_sgl = {32'h00000000, sgn_res, to_inf ? fptu_pkg::SGL_INF_MAG : fptu_pkg::SGL_MAX_MAG};
	wire        ovf_fix = ieee_exc[fptu_pkg::EXC_OVERFLOW];
	wire [63:0] wb_data = !ovf_fix ? op_result_i : (op_dbl_i ? ovf_dbl : ovf_sgl);

	// ****************************************************************
	// Register file write and read selection
	// ****************************************************************
	// trapped op writes nothing
	wire op_wr = take && !op_trap && !op_cmp_i;
	// Move writes to an unavailable odd register in narrow paired mode are dropped.
	wire mv_ok = !(narrow && !width_mode && mv_idx_i[0]);
	wire mv_wr = mv_we_i && !take && mv_ok;

	assign rf_bus.we    = op_wr || mv_wr;
	assign rf_bus.widx  = op_wr ? op_fd_i : mv_idx_i;
	assign rf_bus.wdbl  = op_wr ? op_dbl_i : (mv_dbl_i && !narrow);
	assign rf_bus.wdata = op_wr ? wb_data : mv_wdata_i;
	assign rf_bus.ridx  = mv_idx_i;
	assign rf_bus.mode  = width_mode;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mv_rdata_o <= 64'h0000000000000000;
		end else if (mv_rd_i) begin
			mv_rdata_o <= mv_ok ? rf_bus.rdata : 64'h0000000000000000;
		end
	end

	// ****************************************************************
	// Issue sequencing
	// ****************************************************************
	// inexact enable stops overlap
	wire serial = enables[fptu_pkg::EXC_INEXACT];

	always_comb begin
		next_state = state;
		case (state)
			fptu_pkg::FPTU_ISSUE: begin
				if (take && op_trap) begin
					next_state = fptu_pkg::FPTU_FLUSH;
				end else if (take && serial) begin
					next_state = fptu_pkg::FPTU_SERIAL;
				end
			end
			fptu_pkg::FPTU_SERIAL: begin
				next_state = fptu_pkg::FPTU_ISSUE;
			end
			fptu_pkg::FPTU_FLUSH: begin
				next_state = fptu_pkg::FPTU_ISSUE;
			end
			default: begin
				next_state = fptu_pkg::FPTU_ISSUE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state      <= fptu_pkg::FPTU_ISSUE;
			op_ready_o <= 1'b0;
			op_done_o  <= 1'b0;
			op_trap_o  <= 1'b0;
		end else begin
			state      <= next_state;
			op_ready_o <= (next_state == fptu_pkg::FPTU_ISSUE);
			op_done_o  <= take;
			op_trap_o  <= take && op_trap;
		end
	end

	// ****************************************************************
	// Control register access
	// ****************************************************************
	// only two control numbers decode
	wire csr_sel = (reg_addr_i == fptu_pkg::CR_CSR);
	wire imp_sel = (reg_addr_i == fptu_pkg::CR_IMPREV);
	wire csr_wr  = reg_wr_i && csr_sel;

	wire [31:0] csr_val = (32'(cond) << fptu_pkg::CSR_COND_BIT) |
		(32'(unimp) << fptu_pkg::CSR_UNIMP_BIT) | (32'(cause) << fptu_pkg::CSR_CAUSE_LSB) |
		(32'(enables) << fptu_pkg::CSR_EN_LSB) | (32'(flags) << fptu_pkg::CSR_FLAG_LSB) |
		(32'(rm) << fptu_pkg::CSR_RM_LSB);
	wire [31:0] imp_val = (32'(IMP_CODE) << fptu_pkg::IMP_LSB) | 32'(REV_CODE);
	wire [31:0] rd_val  = csr_sel ? csr_val : (imp_sel ? imp_val : 32'h00000000);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_val;
		end
	end

	// Software fields are taken first; a completing operation then overrides cause and unimp, and cond if it is a compare, and ORs its exceptions into flags.
	wire [4:0] wr_cause = csr_wr ? reg_wdata_i[fptu_pkg::CSR_CAUSE_LSB +: 5] : cause;
	wire [4:0] wr_flags = csr_wr ? reg_wdata_i[fptu_pkg::CSR_FLAG_LSB +: 5] : flags;
	wire       wr_unimp = csr_wr ? reg_wdata_i[fptu_pkg::CSR_UNIMP_BIT] : unimp;
	wire       wr_cond  = csr_wr ? reg_wdata_i[fptu_pkg::CSR_COND_BIT] : cond;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rm      <= fptu_pkg::RM_RESET;
			enables <= fptu_pkg::EXC_RESET;
			cause   <= fptu_pkg::EXC_RESET;
			flags   <= fptu_pkg::EXC_RESET;
			unimp   <= 1'b0;
			cond    <= 1'b0;
		end else begin
			if (csr_wr) begin
				rm      <= reg_wdata_i[fptu_pkg::CSR_RM_LSB +: 2];
				enables <= reg_wdata_i[fptu_pkg::CSR_EN_LSB +: 5];
			end
			cause <= take ? ieee_exc : wr_cause;
			unimp <= take ? op_unimp : wr_unimp;
			flags <= wr_flags | ((take && !op_trap) ? ieee_exc : fptu_pkg::EXC_RESET);
			cond  <= (take && op_cmp_i && !op_trap) ? op_cond_i : wr_cond;
		end
	end

	assign rounding_mode_o = rm;

	// ****************************************************************
	// Trap reporting to the integer pipeline
	// ****************************************************************
	// delay slot returns to branch
	wire [31:0] ret_pc = op_in_delay_i ? op_pc_i - fptu_pkg::INSN_BYTES : op_pc_i;
	wire        exc_fire = !INT_SIGNAL && take && op_trap;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fp_exc_o                  <= 1'b0;
			fp_exception_cause_code_o <= 5'h00;
			epc_o                     <= 32'h00000000;
			branch_delay_flag_o       <= 1'b0;
		end else begin
			fp_exc_o <= exc_fire;
			if (take && op_trap) begin
				fp_exception_cause_code_o <= EXC_CODE;
				epc_o                     <= ret_pc;
				branch_delay_flag_o       <= op_in_delay_i;
			end
		end
	end

	// The interrupt stands while an enabled cause or the unimplemented bit stays set.
	// trap state kept while interrupt disabled
	wire int_pend = INT_SIGNAL && (unimp || |(cause & enables));
	wire int_live = int_pend && cpu_int_enable_i;

	for (genvar i = 0; i < INT_LINES; i++) begin : g_int
		always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				cpu_int_o[i] <= 1'b0;
			end else begin
				cpu_int_o[i] <= int_live && int_line_sel_i == 3'(i);
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/fptu_top_sva.sv
// Concurrent checks on the ports of the floating-point trap unit.
`timescale 1ns/10ps
`default_nettype none
module fptu_top_sva #(
	parameter logic [7:0] IMP_CODE = 8'h5A,
	parameter logic [7:0] REV_CODE = 8'h11,
	parameter logic [4:0] EXC_CODE = 5'h10,
	parameter int         INT_LINES = 6
) (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        register_width_mode_bit_i,
	input  wire logic        op_valid_i,
	input  wire logic [4:0]  op_fs_i,
	input  wire logic [31:0] op_pc_i,
	input  wire logic        op_in_delay_i,
	input  wire logic        op_no_encoding_i,
	input  wire logic        op_opnd_denorm_i,
	input  wire logic        op_ready_o,
	input  wire logic        op_done_o,
	input  wire logic        op_trap_o,
	input  wire logic [4:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [31:0] reg_rdata_o,
	input  wire logic [1:0]  rounding_mode_o,
	input  wire logic [INT_LINES-1:0] cpu_int_o,
	input  wire logic        fp_exc_o,
	input  wire logic [4:0]  fp_exception_cause_code_o,
	input  wire logic [31:0] epc_o,
	input  wire logic        branch_delay_flag_o
);
	logic take;
	logic inx_en;
	assign take = op_valid_i && op_ready_o;
	// Tracks the inexact enable as software last wrote it.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			inx_en <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == fptu_pkg::CR_CSR) begin
			inx_en <= reg_wdata_i[fptu_pkg::CSR_EN_LSB + fptu_pkg::EXC_INEXACT];
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_DONE_NEXT: assert property (take |=> op_done_o)
		else $error("taken op gave no done pulse");
	AST_FLUSH: assert property (op_trap_o |-> !op_ready_o ##1 op_ready_o)
		else $error("trap not followed by one flush cycle");
	AST_EXC_CODE: assert property (op_trap_o |-> fp_exc_o && fp_exception_cause_code_o == EXC_CODE)
		else $error("trap without coded exception");
	AST_EPC: assert property (op_trap_o |->
		epc_o == $past(op_pc_i) - ($past(op_in_delay_i) ? 32'h4 : 32'h0)
		&& branch_delay_flag_o == $past(op_in_delay_i))
		else $error("wrong return address or delay flag");
	AST_UNIMP: assert property (take && (op_no_encoding_i || op_opnd_denorm_i) |=> op_trap_o)
		else $error("unimplemented op did not trap");
	AST_ODD: assert property (take && !register_width_mode_bit_i && op_fs_i[0] |=> op_trap_o)
		else $error("odd register in paired mode did not trap");
	AST_SERIAL: assert property (take && inx_en |=> !op_ready_o)
		else $error("overlap while inexact enabled");
	AST_IMP_READ: assert property (reg_rd_i && reg_addr_i == fptu_pkg::CR_IMPREV
		|=> reg_rdata_o == {16'h0000, IMP_CODE, REV_CODE})
		else $error("implementation register read wrong");
	AST_RSVD_READ: assert property (reg_rd_i && reg_addr_i != fptu_pkg::CR_IMPREV
		&& reg_addr_i != fptu_pkg::CR_CSR |=> reg_rdata_o == 32'h0)
		else $error("reserved control register not zero");
	AST_RM: assert property (reg_wr_i && reg_addr_i == fptu_pkg::CR_CSR
		|=> rounding_mode_o == $past(reg_wdata_i[fptu_pkg::CSR_RM_LSB +: 2]))
		else $error("rounding mode not taken from control write");
	AST_INT_QUIET: assert property (fp_exc_o |=> cpu_int_o == '0)
		else $error("interrupt line raised in exception variant");
	COV_TRAP: cover property (take ##1 op_trap_o);
	COV_SERIAL: cover property (take && inx_en);
	COV_DELAY: cover property (op_trap_o && branch_delay_flag_o);
endmodule
bind fptu_top fptu_top_sva #(.IMP_CODE(IMP_CODE), .REV_CODE(REV_CODE), .EXC_CODE(EXC_CODE),
	.INT_LINES(INT_LINES)) sva (
	.rounding_mode_o(rounding_mode_o), .cpu_int_o(cpu_int_o),
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .register_width_mode_bit_i(register_width_mode_bit_i),
	.op_valid_i(op_valid_i), .op_fs_i(op_fs_i), .op_pc_i(op_pc_i), .op_in_delay_i(op_in_delay_i),
	.op_no_encoding_i(op_no_encoding_i), .op_opnd_denorm_i(op_opnd_denorm_i), .op_ready_o(op_ready_o),
	.op_done_o(op_done_o), .op_trap_o(op_trap_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fp_exc_o(fp_exc_o),
	.fp_exception_cause_code_o(fp_exception_cause_code_o), .epc_o(epc_o),
	.branch_delay_flag_o(branch_delay_flag_o)
);
`default_nettype wire

// >>> verification/fptu_host_model.sv
// Host exception intake that records each floating-point exception handed to it.
`timescale 1ns/10ps
`default_nettype none
module fptu_host_model (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        fp_exc_i,
	input  wire logic [4:0]  code_i,
	input  wire logic [31:0] epc_i,
	input  wire logic        bd_i,
	output logic             taken_o,
	output logic [37:0]      record_o
);
	// The host latches the return state in the cycle the exception is signalled.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			taken_o  <= 1'b0;
			record_o <= 38'h0;
		end else begin
			taken_o <= fp_exc_i;
			if (fp_exc_i) begin
				record_o <= {bd_i, code_i, epc_i};
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/fptu_top_test.sv
// Self-checking bench for the floating-point trap and register unit.
`timescale 1ns/10ps
`default_nettype none
module fptu_top_test;
	// Identification values are arbitrary.
	localparam logic [7:0] IMP_ID  = 8'h3C;
	localparam logic [7:0] REV_ID  = 8'h07;
	localparam logic [4:0] FP_CODE = 5'h17;
	logic        sys_clk_i = 1'b0, reset_n_i = 1'b0, mode = 1'b1, int_en = 1'b0, op_valid_i = 1'b0, dly = 1'b0;
	logic        mv_we_i = 1'b0, mv_rd_i = 1'b0, mv_dbl = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, inx_en;
	logic [2:0]  int_sel = 3'h0, bad = 3'h0;
	logic [4:0]  fs = 5'h00, fd = 5'h00, exc = 5'h00, mv_idx = 5'h00, reg_addr = 5'h00, code;
	logic [31:0] pc = 32'h0, reg_wd = 32'h0, reg_rdata_o, epc;
	logic [63:0] res = 64'h0, mv_wd = 64'h0, mv_rdata_o, d64;
	logic        op_ready_o, op_done_o, op_trap_o, fp_exc_o, bd, taken, mv_rd_d, reg_rd_d;
	logic [37:0] record;
	logic [63:0] q_op[$], q_mv[$], q_reg[$], q_host[$];
	int          fail_count = 0, checks_done = 0, i, seed;
	fptu_top #(.IMP_CODE(IMP_ID), .REV_CODE(REV_ID), .EXC_CODE(FP_CODE)) dut (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .register_width_mode_bit_i(mode),
		.cpu_int_enable_i(int_en), .int_line_sel_i(int_sel), .op_valid_i(op_valid_i), .op_dbl_i(1'b1),
		.op_fs_i(fs), .op_ft_i(fs), .op_fd_i(fd), .op_pc_i(pc), .op_in_delay_i(dly), .op_no_encoding_i(bad[2]),
		.op_opnd_denorm_i(bad[1]), .op_opnd_snan_i(bad[0]), .op_res_denorm_i(1'b0), .op_exc_i(exc),
		.op_result_i(res), .op_cmp_i(1'b0), .op_cond_i(1'b0), .op_ready_o(op_ready_o), .op_done_o(op_done_o),
		.op_trap_o(op_trap_o), .mv_we_i(mv_we_i), .mv_rd_i(mv_rd_i), .mv_idx_i(mv_idx), .mv_dbl_i(mv_dbl),
		.mv_wdata_i(mv_wd), .mv_rdata_o(mv_rdata_o), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wd),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rounding_mode_o(),
		.fp_exc_o(fp_exc_o), .fp_exception_cause_code_o(code), .epc_o(epc), .branch_delay_flag_o(bd),
		.cpu_int_o()
	);
	fptu_host_model host (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .fp_exc_i(fp_exc_o), .code_i(code),
		.epc_i(epc), .bd_i(bd), .taken_o(taken), .record_o(record));
	initial begin
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic reg_acc(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(posedge sys_clk_i);
		reg_wr_i <= wr;
		reg_rd_i <= !wr;
		reg_addr <= a;
		reg_wd   <= d;
		if (!wr) q_reg.push_back({32'h0, exp});
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
	endtask
	task automatic csr_wr(input logic [31:0] v);
		inx_en = v[fptu_pkg::CSR_EN_LSB];
		reg_acc(1'b1, fptu_pkg::CR_CSR, v, 32'h0);
	endtask
	task automatic mv_acc(input logic we, input logic [4:0] k, input logic [63:0] d, input logic [63:0] exp);
		@(posedge sys_clk_i);
		mv_we_i <= we;
		mv_rd_i <= !we;
		mv_idx  <= k;
		mv_dbl  <= 1'b1;
		mv_wd   <= d;
		if (!we) q_mv.push_back(exp);
		@(posedge sys_clk_i);
		mv_we_i <= 1'b0;
		mv_rd_i <= 1'b0;
	endtask
	task automatic op(input logic [4:0] s, input logic [4:0] d, input logic [4:0] e, input logic [2:0] b,
		input logic dl, input logic [63:0] r, input logic trap);
		logic [31:0] p;
		int          n;
		p = $urandom() & 32'hFFFFFFFC;
		@(posedge sys_clk_i);
		op_valid_i <= 1'b1;
		{fs, fd, exc, bad, dly, res, pc} <= {s, d, e, b, dl, r, p};
		q_op.push_back({62'h0, trap, !(trap || inx_en)});
		if (trap) q_host.push_back({26'h0, dl, FP_CODE, p - (dl ? 32'h4 : 32'h0)});
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (op_ready_o !== 1'b1 && n < 20);
		if (n == 20) fail_count++;
		@(posedge sys_clk_i);
		op_valid_i <= 1'b0;
	endtask
	// ****************************************************************
	// Result monitor
	// ****************************************************************
	always @(posedge sys_clk_i) begin
		mv_rd_d  <= mv_rd_i;
		reg_rd_d <= reg_rd_i;
	end
	always @(negedge sys_clk_i) begin
		if (op_done_o === 1'b1) check({62'h0, op_trap_o, op_ready_o}, q_op.pop_front());
		if (mv_rd_d === 1'b1) check(mv_rdata_o, q_mv.pop_front());
		if (reg_rd_d === 1'b1) check({32'h0, reg_rdata_o}, q_reg.pop_front());
		if (taken === 1'b1) check({26'h0, record}, q_host.pop_front());
	end
	initial begin
		#(40 * 5000);
		fail_count++;
		test_done();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = $urandom(31);
		inx_en = 1'b0;
		int_en = 1'($urandom());
		int_sel = 3'($urandom());
		repeat (2) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		reg_acc(1'b0, fptu_pkg::CR_CSR, 32'h0, 32'h0);
		reg_acc(1'b0, fptu_pkg::CR_IMPREV, 32'h0, {16'h0, IMP_ID, REV_ID});
		for (i = 0; i < 4; i++) begin
			reg_acc(1'b1, 5'($urandom_range(30, 1)), $urandom(), 32'h0);
			reg_acc(1'b0, 5'($urandom_range(30, 1)), 32'h0, 32'h0);
			d64 = {$urandom(), $urandom()};
			mv_acc(1'b1, 5'(i * 7 + 1), d64, 64'h0);
			mv_acc(1'b0, 5'(i * 7 + 1), 64'h0, d64);
		end
		reg_acc(1'b0, fptu_pkg::CR_CSR, 32'h0, 32'h0);
		@(posedge sys_clk_i);
		mode <= 1'b0;
		d64 = {$urandom(), $urandom()};
		mv_acc(1'b1, 5'h06, d64, 64'h0);
		mv_acc(1'b0, 5'h07, 64'h0, {2{d64[63:32]}});
		op(5'h03, 5'h06, 5'h00, 3'h0, 1'b1, 64'h1, 1'b1);
		mv_acc(1'b0, 5'h06, 64'h0, d64);
		op(5'h02, 5'h08, 5'h00, 3'h0, 1'b0, d64 + 1, 1'b0);
		mv_acc(1'b0, 5'h08, 64'h0, d64 + 1);
		@(posedge sys_clk_i);
		mode <= 1'b1;
		op(5'h05, 5'h09, 5'h00, 3'h2, 1'b1, d64, 1'b1);
		op(5'h05, 5'h09, 5'h00, 3'h4, 1'b0, d64, 1'b1);
		op(5'h05, 5'h09, 5'h00, 3'h1, 1'b1, d64, 1'b1);
		for (i = 0; i < 5; i++) begin
			op(5'h01, 5'h0B, 5'(1 << i), 3'h0, 1'($urandom()), d64, i == 1 || i == 4);
		end
		for (i = 0; i < 4; i++) begin
			csr_wr(32'(i));
			op(5'h01, 5'h0C, 5'h04, 3'h0, 1'b0, 64'h3FF0000000000000, 1'b0);
			mv_acc(1'b0, 5'h0C, 64'h0, {1'b0, i[0] ? fptu_pkg::DBL_MAX_MAG : fptu_pkg::DBL_INF_MAG});
			reg_acc(1'b0, fptu_pkg::CR_CSR, 32'h0, 32'(i) | 32'h4010);
		end
		csr_wr(32'h400);
		op(5'h01, 5'h0D, 5'h08, 3'h0, 1'b0, d64, 1'b1);
		csr_wr(32'h80);
		op(5'h01, 5'h0D, 5'h00, 3'h0, 1'b0, d64, 1'b0);
		op(5'h01, 5'h0D, 5'h01, 3'h0, 1'b1, d64, 1'b1);
		csr_wr(32'h0);
		repeat (4) @(posedge sys_clk_i);
		test_done();
	end
endmodule
`default_nettype wire
